// file: src/smc_cfg.svh
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// Register byte addresses
`define SMC_ADDR_MODE 8'h00
`define SMC_ADDR_DIV 8'h04
`define SMC_ADDR_CTRL 8'h08
`define SMC_ADDR_TXDATA 8'h0C
`define SMC_ADDR_RXDATA 8'h10
`define SMC_ADDR_STATUS 8'h14
`define SMC_ADDR_CLEAR 8'h18
`define SMC_ADDR_IRQEN 8'h1C

// Fields of serial_mode_reg
`define SMC_MODE_SYNC 7
`define SMC_MODE_CHAR7 6
`define SMC_MODE_PARITY 5
`define SMC_MODE_STOP2 3
`define SMC_MODE_MULTI 2

// Fields of serial_ctrl_reg
`define SMC_CTRL_TX_ON 5
`define SMC_CTRL_RX_ON 4
`define SMC_CTRL_MPB_TX 2
`define SMC_CTRL_SRC1 1
`define SMC_CTRL_SRC0 0

// Status, clear and enable layout
`define SMC_STS_W 7
`define SMC_STS_RX_RDY 0
`define SMC_STS_TX_EMPTY 1
`define SMC_STS_OVR 2
`define SMC_STS_FER 3
`define SMC_STS_PER 4
`define SMC_STS_BRK 5
`define SMC_STS_TX_END 6

// Reset values
`define SMC_RST_MODE 8'h00
`define SMC_RST_CTRL 8'h00
`define SMC_RST_DIV 8'h00
`define SMC_RST_IRQEN 7'h00

// Sixteen-times oversampling points
`define SMC_OVS_MID 4'h7
`define SMC_OVS_LAST 4'hF

`endif

// file: src/smc_pkg.sv
`include "smc_cfg.svh"

package smc_pkg;

    typedef enum logic [1:0]
    {
        SMC_RX_IDLE = 2'b00,
        SMC_RX_START = 2'b01,
        SMC_RX_DATA = 2'b11,
        SMC_RX_STOP = 2'b10
    } smc_rx_e;

    typedef logic [`SMC_STS_W-1:0] smc_sts_t;

endpackage : smc_pkg

// file: src/smc_clk.sv
`timescale 1ns/1ns
`default_nettype none

module smc_clk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sync_mode,
    input wire logic src1,
    input wire logic src0,
    input wire logic run,
    input wire logic [7:0] divisor,
    input wire logic sck_in,
    output logic tick16,
    output logic rise,
    output logic fall,
    output logic [3:0] phase,
    output logic sck_out,
    output logic sck_oe
);

    logic [7:0] brg_cnt;
    logic brg_tick;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic ext_rise;
    logic ext_fall;
    logic sck_q;

    always_ff @(posedge clock)
    begin
        if (!nrst || src1 || brg_cnt == divisor)
            brg_cnt <= 8'h00;
        else
            brg_cnt <= brg_cnt + 8'h01;
    end

    assign brg_tick = ~src1 && brg_cnt == divisor;

    // Pin clock resynchronised; edges only from the second stage on
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sck_m <= 1'b1;
            sck_s <= 1'b1;
            sck_d <= 1'b1;
        end
        else
        begin
            sck_m <= sck_in;
            sck_s <= sck_m;
            sck_d <= sck_s;
        end
    end

    assign ext_rise = sck_s & ~sck_d;
    assign ext_fall = ~sck_s & sck_d;

    assign tick16 = ~sync_mode & (src1 ? ext_rise : brg_tick);

    assign rise = sync_mode & (src1 ? ext_rise : brg_tick & ~sck_q);
    assign fall = sync_mode & (src1 ? ext_fall : brg_tick & sck_q & run);

    always_ff @(posedge clock)
    begin
        if (!nrst || !sync_mode || src1)
            sck_q <= 1'b1;
        else if (fall)
            sck_q <= 1'b0;
        else if (rise)
            sck_q <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            phase <= 4'h0;
        else if (tick16)
            phase <= phase + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sck_oe <= 1'b0;
            sck_out <= 1'b1;
        end
        else
        begin
            sck_oe <= ~src1 & (sync_mode | src0);
            if (src1)
                sck_out <= 1'b1;
            else if (sync_mode)
                sck_out <= sck_q;
            else
                sck_out <= ~src0 | phase[3];
        end
    end

endmodule : smc_clk

`default_nettype wire

// file: src/smc_top.sv
// What this block does
// - Two modes: framed characters or clocked
// - Mode bit 7: 0 framed, 1 clocked
// - Bit 6: 8 data bits or 7
// - Bit 3: one or two stop bits
// - Bit 5 parity; bit 2 multiprocessor replaces it
// - Framed receive flags framing, parity, overrun, break
// - Clocked mode: 8 bits, nothing added
// - Clocked receive flags only overrun
// - Clock source from mode and control bits
// - Framed, 00: internal clock, pin unused
// - Framed, 01: internal, pin outputs bit clock
// - Framed, 1x: pin gives sixteen-times clock
// - Clocked, 0x: internal, clock driven out
// - Clocked, 1x: shift on pin clock
// - Low start, LSB first, extra, high stops
`include "smc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module smc_top (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic rxd,
    output logic txd,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic irq
);

    logic [7:0] serial_mode_reg;
    logic [7:0] serial_ctrl_reg;
    logic [7:0] bit_rate_divisor_reg;
    smc_pkg::smc_sts_t sts;
    smc_pkg::smc_sts_t irq_en;
    smc_pkg::smc_sts_t sts_set;
    smc_pkg::smc_sts_t sts_clr;
    logic mode_sync;
    logic char7;
    logic multiproc_format_select;
    logic parity_on;
    logic stop2;
    logic has_extra;
    logic [3:0] data_len;
    logic tx_on_bit;
    logic rx_on_bit;
    logic clock_src_bit1;
    logic clock_src_bit0;
    logic tick16;
    logic rise;
    logic fall;
    logic [3:0] phase;
    logic run;

    assign mode_sync = serial_mode_reg[`SMC_MODE_SYNC];
    assign char7 = ~mode_sync & serial_mode_reg[`SMC_MODE_CHAR7];
    assign multiproc_format_select =
        ~mode_sync & serial_mode_reg[`SMC_MODE_MULTI];
    assign parity_on = ~mode_sync & ~multiproc_format_select &
        serial_mode_reg[`SMC_MODE_PARITY];
    assign stop2 = ~mode_sync & serial_mode_reg[`SMC_MODE_STOP2];
    assign has_extra = parity_on | multiproc_format_select;
    assign data_len = char7 ? 4'd7 : 4'd8;
    assign tx_on_bit = serial_ctrl_reg[`SMC_CTRL_TX_ON];
    assign rx_on_bit = serial_ctrl_reg[`SMC_CTRL_RX_ON];
    assign clock_src_bit1 = serial_ctrl_reg[`SMC_CTRL_SRC1];
    assign clock_src_bit0 = serial_ctrl_reg[`SMC_CTRL_SRC0];

    smc_clk u_clk (
        .clock(clock),
        .nrst(nrst),
        .sync_mode(mode_sync),
        .src1(clock_src_bit1),
        .src0(clock_src_bit0),
        .run(run),
        .divisor(bit_rate_divisor_reg),
        .sck_in(sck_in),
        .tick16(tick16),
        .rise(rise),
        .fall(fall),
        .phase(phase),
        .sck_out(sck_out),
        .sck_oe(sck_oe)
    );

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            serial_mode_reg <= `SMC_RST_MODE;
            serial_ctrl_reg <= `SMC_RST_CTRL;
            bit_rate_divisor_reg <= `SMC_RST_DIV;
            irq_en <= `SMC_RST_IRQEN;
        end
        else if (wr)
        begin
            if (addr == `SMC_ADDR_MODE)
                serial_mode_reg <= wdata[7:0];
            if (addr == `SMC_ADDR_CTRL)
                serial_ctrl_reg <= wdata[7:0];
            if (addr == `SMC_ADDR_DIV)
                bit_rate_divisor_reg <= wdata[7:0];
            if (addr == `SMC_ADDR_IRQEN)
                irq_en <= wdata[`SMC_STS_W-1:0];
        end
    end

    // Transmitter
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] tx_data8;
    logic tx_extra;
    logic [11:0] tx_frame;
    logic [3:0] frame_len;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic tx_busy;
    logic tx_step;
    logic tx_load;
    logic tx_end;

    assign tx_data8 = char7 ? {1'b0, tx_hold[6:0]} : tx_hold;
    assign tx_extra = parity_on ? ^tx_data8 :
        serial_ctrl_reg[`SMC_CTRL_MPB_TX];

    // data LSB first, extra bit, high stops
    always_comb
    begin
        tx_frame = {4'hF, tx_data8};
        if (char7)
            tx_frame[7] = 1'b1;
        if (has_extra)
            tx_frame[data_len] = tx_extra;
    end

    assign frame_len = data_len + {3'b000, has_extra} +
        (stop2 ? 4'd2 : 4'd1);
    assign tx_step = mode_sync ? fall :
        tick16 && phase == `SMC_OVS_LAST;
    assign tx_load = tx_step & tx_on_bit & tx_full &
        (~tx_busy | tx_left == 4'd0);
    assign tx_end = tx_step & tx_on_bit & tx_busy &
        tx_left == 4'd0 & ~tx_full;
    assign run = tx_on_bit & (tx_busy | tx_full) | rx_on_bit;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            tx_full <= 1'b0;
            tx_hold <= 8'h00;
        end
        else
        begin
            if (!tx_on_bit || tx_load)
                tx_full <= 1'b0;
            if (wr && addr == `SMC_ADDR_TXDATA && tx_on_bit)
            begin
                tx_hold <= wdata[7:0];
                tx_full <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst || !tx_on_bit)
        begin
            txd <= 1'b1;
            tx_busy <= 1'b0;
            tx_sh <= 12'hFFF;
            tx_left <= 4'd0;
        end
        else if (tx_step)
        begin
            if (tx_busy && tx_left != 4'd0)
            begin
                txd <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[11:1]};
                tx_left <= tx_left - 4'd1;
            end
            else if (tx_full)
            begin
                tx_busy <= 1'b1;
                if (mode_sync)
                begin
                    txd <= tx_hold[0];
                    tx_sh <= {5'h1F, tx_hold[7:1]};
                    tx_left <= 4'd7;
                end
                else
                begin
                    txd <= 1'b0;
                    tx_sh <= tx_frame;
                    tx_left <= frame_len;
                end
            end
            else
            begin
                tx_busy <= 1'b0;
                txd <= 1'b1;
            end
        end
    end

    // Receiver
    logic rxd_m;
    logic rxd_s;
    smc_pkg::smc_rx_e rx_st;
    logic [3:0] rx_cnt;
    logic [3:0] rx_n;
    logic [3:0] rx_last;
    logic [8:0] rx_sh;
    logic [8:0] rx_word;
    logic [8:0] rx_data;
    logic rx_done;
    logic rx_fer;
    logic rx_per;
    logic rx_brk;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
        end
        else
        begin
            rxd_m <= rxd;
            rxd_s <= rxd_m;
        end
    end

    assign rx_last = data_len + {3'b000, has_extra} - 4'd1;
    assign rx_word[7:0] = char7 ? {1'b0, rx_sh[6:0]} : rx_sh[7:0];
    assign rx_word[8] = multiproc_format_select &
        (char7 ? rx_sh[7] : rx_sh[8]);

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rx_st <= smc_pkg::SMC_RX_IDLE;
            rx_cnt <= 4'h0;
            rx_n <= 4'h0;
            rx_sh <= 9'h000;
            rx_done <= 1'b0;
            rx_fer <= 1'b0;
            rx_per <= 1'b0;
            rx_brk <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            rx_fer <= 1'b0;
            rx_per <= 1'b0;
            rx_brk <= 1'b0;
            if (!rx_on_bit)
            begin
                rx_st <= smc_pkg::SMC_RX_IDLE;
                rx_n <= 4'h0;
            end
            else if (mode_sync)
            begin
                // clocked receive raises no format errors
                rx_st <= smc_pkg::SMC_RX_IDLE;
                if (rise)
                begin
                    rx_sh[rx_n] <= rxd_s;
                    rx_n <= rx_n == 4'd7 ? 4'h0 : rx_n + 4'd1;
                    rx_done <= rx_n == 4'd7;
                end
            end
            else if (tick16)
            begin
                unique case (rx_st)
                    smc_pkg::SMC_RX_IDLE:
                    begin
                        rx_cnt <= 4'h0;
                        rx_n <= 4'h0;
                        rx_sh <= 9'h000;
                        if (!rxd_s)
                            rx_st <= smc_pkg::SMC_RX_START;
                    end
                    smc_pkg::SMC_RX_START:
                    begin
                        rx_cnt <= rx_cnt + 4'd1;
                        if (rx_cnt == `SMC_OVS_MID)
                        begin
                            rx_cnt <= 4'h0;
                            rx_st <= rxd_s ? smc_pkg::SMC_RX_IDLE :
                                smc_pkg::SMC_RX_DATA;
                        end
                    end
                    smc_pkg::SMC_RX_DATA:
                    begin
                        rx_cnt <= rx_cnt + 4'd1;
                        if (rx_cnt == `SMC_OVS_LAST)
                        begin
                            rx_sh[rx_n] <= rxd_s;
                            rx_n <= rx_n + 4'd1;
                            if (rx_n == rx_last)
                                rx_st <= smc_pkg::SMC_RX_STOP;
                        end
                    end
                    smc_pkg::SMC_RX_STOP:
                    begin
                        rx_cnt <= rx_cnt + 4'd1;
                        if (rx_cnt == `SMC_OVS_LAST)
                        begin
                            rx_st <= smc_pkg::SMC_RX_IDLE;
                            rx_done <= 1'b1;
                            rx_fer <= ~rxd_s;
                            rx_brk <= ~rxd_s & ~|rx_sh;
                            rx_per <= parity_on & ^rx_sh;
                        end
                    end
                endcase
            end
        end
    end

    // Status, overrun and interrupt; a set beats a clear
    always_comb
    begin
        sts_set = '0;
        sts_set[`SMC_STS_RX_RDY] = rx_done;
        sts_set[`SMC_STS_TX_EMPTY] = tx_load;
        sts_set[`SMC_STS_OVR] = rx_done & sts[`SMC_STS_RX_RDY];
        sts_set[`SMC_STS_FER] = rx_fer;
        sts_set[`SMC_STS_PER] = rx_per;
        sts_set[`SMC_STS_BRK] = rx_brk;
        sts_set[`SMC_STS_TX_END] = tx_end;
    end

    assign sts_clr = (wr && addr == `SMC_ADDR_CLEAR) ?
        wdata[`SMC_STS_W-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (!nrst)
            sts <= '0;
        else
            sts <= (sts & ~sts_clr) | sts_set;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            rx_data <= 9'h000;
        else if (rx_done && !sts[`SMC_STS_RX_RDY])
            rx_data <= rx_word;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(sts & irq_en);
    end

    always_ff @(posedge clock)
    begin
        if (!nrst || !rd)
            rdata <= 32'h0000_0000;
        else
            unique case (addr)
                `SMC_ADDR_MODE: rdata <= 32'(serial_mode_reg);
                `SMC_ADDR_CTRL: rdata <= 32'(serial_ctrl_reg);
                `SMC_ADDR_DIV: rdata <= 32'(bit_rate_divisor_reg);
                `SMC_ADDR_RXDATA: rdata <= 32'(rx_data);
                `SMC_ADDR_STATUS: rdata <= 32'(sts);
                `SMC_ADDR_IRQEN: rdata <= 32'(irq_en);
                default: rdata <= 32'h0000_0000;
            endcase
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    async_start_a: assert property (
        tx_load & ~mode_sync |=> ~txd && tx_left == $past(frame_len))
        else $error("framed start bit or length wrong");

    stop_len_a: assert property (
        tx_load & ~mode_sync & ~char7 & ~has_extra & stop2
        |=> tx_left == 4'd10)
        else $error("two stop bits not counted");

    multi_bit_a: assert property (
        tx_load & ~mode_sync & char7 & multiproc_format_select &
        ~stop2 |=> tx_left == 4'd9 &&
        tx_sh[7] == $past(serial_ctrl_reg[`SMC_CTRL_MPB_TX]))
        else $error("multiprocessor bit not in place of parity");

    sync_len_a: assert property (
        tx_load & mode_sync |=> tx_left == 4'd7 &&
        txd == $past(tx_hold[0]))
        else $error("clocked frame not plain 8 bits");

    sync_err_a: assert property (
        mode_sync |-> ~rx_fer & ~rx_per & ~rx_brk)
        else $error("format error in clocked mode");

    brk_fer_a: assert property (
        rx_brk |-> rx_fer)
        else $error("break without framing error");

    overrun_a: assert property (
        rx_done & sts[`SMC_STS_RX_RDY] |=> sts[`SMC_STS_OVR] &&
        rx_data == $past(rx_data))
        else $error("overrun not flagged or data lost");

    pin_off_a: assert property (
        (~mode_sync & ~clock_src_bit1 & ~clock_src_bit0) [*2]
        |-> ~sck_oe)
        else $error("clock pin driven while unused");

    pin_drive_a: assert property (
        (~clock_src_bit1 & (mode_sync | clock_src_bit0)) [*2]
        |-> sck_oe)
        else $error("internal clock not driven out");

    ext_tick_a: assert property (
        tick16 & clock_src_bit1 |-> $past(sck_in, 2) &&
        !$past(sck_in, 3))
        else $error("oversample tick not from clock pin");

    ext_shift_a: assert property (
        rise & mode_sync & clock_src_bit1 |-> $past(sck_in, 2) &&
        !$past(sck_in, 3) && ~sck_oe)
        else $error("clocked shift not from pin clock");

    async_rx_c: cover property (rx_done & ~mode_sync & ~rx_fer);
    sync_rx_c: cover property (rx_done & mode_sync);
    tx_end_c: cover property (tx_end ##1 sts[`SMC_STS_TX_END]);

endmodule : smc_top

`default_nettype wire

// file: sim/smc_far_end.sv
`timescale 1ns/1ns
`default_nettype none

module smc_far_end (
    input wire logic clock,
    input wire logic txd,
    input wire logic sck_out,
    output logic rxd,
    output logic sck_in
);
    logic ext_run = 1'b0;
    logic sync_sck = 1'b1;
    logic [1:0] cnt = 2'b00;

    initial
    begin
        rxd = 1'b1;
        sck_in = 1'b1;
    end

    always @(posedge clock)
    begin
        cnt <= cnt + 2'b01;
        sck_in <= ext_run ? cnt[1] : sync_sck;
    end

    task automatic send(input logic [12:0] bits, input int len,
                        input int bc, input logic ext);
        ext_run <= ext;
        repeat (ext ? 64 : 0) @(posedge clock);
        for (int i = 0; i < len; i++)
        begin
            rxd <= bits[i];
            repeat (bc) @(posedge clock);
        end
        rxd <= 1'b1;
        ext_run <= 1'b0;
    endtask : send

    task automatic sync_send(input logic [7:0] d);
        for (int i = 0; i < 8; i++)
        begin
            rxd <= d[i];
            sync_sck <= 1'b0;
            repeat (3) @(posedge clock);
            sync_sck <= 1'b1;
            repeat (3) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask : sync_send

    task automatic grab(input int len, output logic [12:0] bits,
                        output logic ok);
        int n;
        // Unsampled positions read as idle line so they match the stops
        bits = '1;
        n = 0;
        while (txd !== 1'b0 && n < 4000)
        begin
            @(posedge clock);
            n++;
        end
        ok = n < 4000;
        repeat (8) @(posedge clock);
        for (int i = 0; i < len; i++)
        begin
            bits[i] = txd;
            repeat (16) @(posedge clock);
        end
    endtask : grab

    task automatic grab_sync(output logic [7:0] d, output logic ok);
        int n;
        int k;
        logic p;
        n = 0;
        k = 0;
        d = '0;
        p = sck_out;
        while (k < 8 && n < 2000)
        begin
            @(posedge clock);
            n++;
            if (sck_out && !p)
            begin
                d[k] = txd;
                k++;
            end
            p = sck_out;
        end
        ok = k == 8;
    endtask : grab_sync
endmodule : smc_far_end

`default_nettype wire

// file: sim/smc_top_tb_top.sv
`include "smc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module smc_top_tb_top;
    logic clock;
    logic nrst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic rxd;
    logic txd;
    logic sck_in;
    logic sck_out;
    logic sck_oe;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 47;
    int n;
    logic [31:0] v;
    logic [12:0] fr;
    logic [12:0] got;
    logic [7:0] d;
    logic [7:0] m;
    logic b;
    logic ok;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h1c, 8'h20, 8'h18};
    logic [31:0] ex[4] = '{32'h10, 32'h08, 32'h28, 32'h04};

    smc_top i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq));

    smc_far_end i_far (.clock(clock), .txd(txd), .sck_out(sck_out),
        .rxd(rxd), .sck_in(sck_in));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic wreg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [31:0] x);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 x = rdata;
    endtask : rreg

    // Expected line bits: start, data, extra, stops
    function automatic logic [12:0] frame(input logic [7:0] md,
        input logic [7:0] x, input logic mb, output int len);
        logic [12:0] f;
        int nd;
        f = '1;
        nd = md[6] ? 7 : 8;
        f[0] = 1'b0;
        for (int i = 0; i < nd; i++)
            f[i + 1] = x[i];
        len = nd + 1;
        if (md[2] || md[5])
        begin
            f[len] = md[2] ? mb : ^(x & (md[6] ? 8'h7f : 8'hff));
            len++;
        end
        len = len + (md[3] ? 2 : 1);
        return f;
    endfunction : frame

    initial
    begin
        repeat (100000) @(posedge clock);
        fail_count++;
        close_out();
    end

    initial
    begin
        nrst = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        #1 chk("reset pins", {irq, sck_oe, txd}, 3'b001);
        foreach (ra[i])
        begin
            rreg(ra[i], v);
            chk("reset read", v, 0);
        end
        for (int i = 0; i < 8; i++)
        begin
            wreg(`SMC_ADDR_MODE, {i[2], 7'h00});
            wreg(`SMC_ADDR_CTRL, i[1:0]);
            repeat (2) @(posedge clock);
            #1 chk("pin enable", sck_oe, i[2] ? !i[1] : i[1:0] == 2'b01);
        end
        wreg(`SMC_ADDR_DIV, 0);
        for (int f = 0; f < 16; f++)
        begin
            m = {1'b0, f[3], f[2], 1'b0, f[1], f[0], 2'b00};
            b = $random(seed);
            d = $random(seed);
            wreg(`SMC_ADDR_CTRL, 0);
            wreg(`SMC_ADDR_MODE, m);
            wreg(`SMC_ADDR_CTRL, {26'h0, 2'b11, 1'b0, b, 2'b00});
            wreg(`SMC_ADDR_CLEAR, 32'h7f);
            wreg(`SMC_ADDR_TXDATA, d);
            fr = frame(m, d, b, n);
            i_far.grab(n, got, ok);
            chk("tx frame", {ok, got}, {1'b1, fr});
            i_far.send(fr, n, 16, 1'b0);
            repeat (4) @(posedge clock);
            rreg(`SMC_ADDR_RXDATA, v);
            chk("rx data", v & {m[2], m[6] ? 8'h7f : 8'hff}, {b, d}
                & {m[2], m[6] ? 8'h7f : 8'hff});
            rreg(`SMC_ADDR_STATUS, v);
            chk("rx status", v & 32'h3d, 32'h01);
        end
        wreg(`SMC_ADDR_CTRL, 0);
        wreg(`SMC_ADDR_MODE, 8'h20);
        wreg(`SMC_ADDR_CTRL, 32'h10);
        wreg(`SMC_ADDR_IRQEN, 32'h3c);
        for (int k = 0; k < 4; k++)
        begin
            wreg(`SMC_ADDR_CLEAR, 32'h7f);
            d = $random(seed);
            fr = frame(8'h20, d, 1'b0, n);
            if (k == 0)
                fr[9] = ~fr[9];
            if (k == 1)
                fr[10] = 1'b0;
            if (k == 2)
                fr = '0;
            i_far.send(fr, n, 16, 1'b0);
            if (k == 3)
                i_far.send(fr, n, 16, 1'b0);
            repeat (4) @(posedge clock);
            rreg(`SMC_ADDR_STATUS, v);
            chk("rx error flags", v & 32'h3c, ex[k]);
            chk("irq raised", irq, 1'b1);
        end
        wreg(`SMC_ADDR_IRQEN, 0);
        repeat (2) @(posedge clock);
        #1 chk("irq masked", irq, 1'b0);
        wreg(`SMC_ADDR_IRQEN, 32'h3c);
        wreg(`SMC_ADDR_CLEAR, 32'h7f);
        repeat (2) @(posedge clock);
        #1 chk("irq cleared", irq, 1'b0);
        wreg(`SMC_ADDR_CTRL, 0);
        wreg(`SMC_ADDR_MODE, 0);
        wreg(`SMC_ADDR_CTRL, 32'h12);
        d = $random(seed);
        fr = frame(8'h00, d, 1'b0, n);
        i_far.send(fr, n, 64, 1'b1);
        repeat (8) @(posedge clock);
        rreg(`SMC_ADDR_RXDATA, v);
        chk("ext clock rx", v[7:0], d);
        wreg(`SMC_ADDR_CTRL, 0);
        wreg(`SMC_ADDR_MODE, 8'hec);
        wreg(`SMC_ADDR_DIV, 1);
        wreg(`SMC_ADDR_CTRL, 32'h20);
        d = $random(seed);
        wreg(`SMC_ADDR_TXDATA, d);
        i_far.grab_sync(got[7:0], ok);
        chk("sync tx", {ok, got[7:0]}, {1'b1, d});
        wreg(`SMC_ADDR_CTRL, 0);
        wreg(`SMC_ADDR_CTRL, 32'h12);
        wreg(`SMC_ADDR_CLEAR, 32'h7f);
        d = $random(seed);
        for (int k = 0; k < 2; k++)
        begin
            i_far.sync_send(d);
            repeat (8) @(posedge clock);
            rreg(`SMC_ADDR_STATUS, v);
            chk("sync rx flags", v & 32'h3d, k ? 32'h05 : 32'h01);
        end
        rreg(`SMC_ADDR_RXDATA, v);
        chk("sync rx data", v[7:0], d);
        close_out();
    end
endmodule : smc_top_tb_top

`default_nettype wire
